// file: common/slc_map.vh
// Register map, field positions and timing counts of the segment LCD controller
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

`define SLC_RAM_BASE 16'hF740
`define SLC_RAM_BYTES 8'h14
`define SLC_PDC_ADDR 16'hFFC0
`define SLC_DSC_ADDR 16'hFFC1
`define SLC_PDC_RESET 8'h00
`define SLC_DSC_RESET 8'h80

`define SLC_PDC_DUTY_HI 7
`define SLC_PDC_DUTY_LO 6
`define SLC_PDC_REUSE 5
`define SLC_PDC_EXP 4
`define SLC_PDC_GRP_HI 3
`define SLC_PDC_GRP_LO 0
`define SLC_DSC_ON 7
`define SLC_DSC_FRM_HI 3
`define SLC_DSC_FRM_LO 0

`define SLC_DUTY_STATIC 2'h0
`define SLC_DUTY_HALF 2'h1
`define SLC_DUTY_THIRD 2'h2
`define SLC_DUTY_QUARTER 2'h3

`define SLC_FRM_MAX 4'hA
`define SLC_INT_SEGS 8'h24
`define SLC_EXT_STATIC 8'h7C
`define SLC_EXT_HALF 8'h2C
`define SLC_SEG_GROUPS 4'hA
`define SLC_SHIFT_DIV 24'h00_0004

`endif

// file: src/slc_sync.v
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module slc_sync (
  // Clock and reset
  input wire refClk,
  input wire srst,
  // Level in and out
  input wire asyncIn,
  output reg syncOut
);
  reg stage1_q;

  always @(posedge refClk) begin
    if (srst) begin
      stage1_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule
`default_nettype wire

// file: src/slc_frame_div.v
// Clock divider giving a one-cycle enable pulse every 'divisor' cycles
`timescale 1ns/100ps
`default_nettype none
module slc_frame_div (
  // Clock and reset
  input wire refClk,
  input wire srst,
  // Control
  input wire run,
  input wire [23:0] divisor,
  // Enable pulse
  output reg tick
);
  reg [23:0] count_q;

  always @(posedge refClk) begin
    if (srst || !run) begin
      count_q <= 24'h00_0000;
      tick <= 1'b0;
    end else if (count_q + 24'h00_0001 >= divisor) begin
      count_q <= 24'h00_0000;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 24'h00_0001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: src/slc_top.v
// Segment LCD controller: registers, display RAM, frame sequencer and pin drive
`timescale 1ns/100ps
`default_nettype none
`include "slc_map.vh"
module slc_top #(
  parameter [23:0] PHASE_BASE = 24'h00_0400
) (
  // Clock and reset
  input wire refClk,
  input wire srst,
  // Register port
  input wire [15:0] busAddr,
  input wire [15:0] busWrData,
  input wire busWordAcc,
  input wire busWrStb,
  input wire busRdStb,
  output reg [15:0] busRdData,
  // Chip mode
  input wire standbyReq,
  // Panel pins
  output reg [39:0] frontPlaneOutputs,
  output reg [39:0] frontPlanePortMode,
  output reg [3:0] backPlaneOutputs,
  output reg [3:0] backPlanePortMode
);
  localparam [1:0] SH_IDLE = 2'b00;
  localparam [1:0] SH_SETUP = 2'b01;
  localparam [1:0] SH_HIGH = 2'b10;
  localparam [1:0] SH_LATCH = 2'b11;

  reg [7:0] lcdPinDutyControl_q;
  reg [7:0] lcdDisplayControl_q;
  reg [7:0] ramMem_q [0:19];
  reg [1:0] phase_q;
  reg alt_q;
  reg [1:0] shState_q;
  reg [7:0] shIdx_q;
  reg [7:0] shCount_q;
  reg serialData_q;
  reg shiftClock_q;
  reg latchClock_q;

  wire standbySync;
  wire phaseTick;
  wire shiftTick;
  wire [159:0] ramBits;
  wire [1:0] dutySel;
  wire reuseCommons;
  wire expansionSel;
  wire [3:0] groupSel;
  wire [3:0] frameSel;
  wire displayRun;
  wire [1:0] lastPhase;
  wire [2:0] comCount;
  wire [23:0] phaseDiv;
  reg [3:0] groupCount;
  reg [7:0] extCount;
  integer i;

  assign dutySel = lcdPinDutyControl_q[`SLC_PDC_DUTY_HI:`SLC_PDC_DUTY_LO];
  assign reuseCommons = lcdPinDutyControl_q[`SLC_PDC_REUSE];
  assign expansionSel = lcdPinDutyControl_q[`SLC_PDC_EXP];
  assign groupSel = lcdPinDutyControl_q[`SLC_PDC_GRP_HI:`SLC_PDC_GRP_LO];
  assign frameSel = lcdDisplayControl_q[`SLC_DSC_FRM_HI:`SLC_DSC_FRM_LO];
  assign lastPhase = dutySel;
  assign comCount = {1'b0, dutySel} + 3'h1;
  // Standby stops all refresh activity
  assign displayRun = lcdDisplayControl_q[`SLC_DSC_ON] & ~standbySync;

  // Eleven phase rates, base period doubled per step, top codes clamp
  assign phaseDiv = (frameSel > `SLC_FRM_MAX) ? (PHASE_BASE << `SLC_FRM_MAX) :
                    (PHASE_BASE << frameSel);

  genvar g;
  generate
    for (g = 0; g < 20; g = g + 1) begin : gRamFlat
      assign ramBits[g*8+7:g*8] = ramMem_q[g];
    end
  endgenerate

  slc_sync uStandbySync (
    .refClk(refClk),
    .srst(srst),
    .asyncIn(standbyReq),
    .syncOut(standbySync)
  );

  slc_frame_div uPhaseDiv (
    .refClk(refClk),
    .srst(srst),
    .run(displayRun),
    .divisor(phaseDiv),
    .tick(phaseTick)
  );

  slc_frame_div uShiftDiv (
    .refClk(refClk),
    .srst(srst),
    .run(displayRun),
    .divisor(`SLC_SHIFT_DIV),
    .tick(shiftTick)
  );

  // Byte read view of the register space
  function [7:0] readByte;
    input [15:0] a;
    reg [15:0] off;
    begin
      off = a - `SLC_RAM_BASE;
      if (a >= `SLC_RAM_BASE && off < {8'h00, `SLC_RAM_BYTES}) begin
        readByte = ramMem_q[off[4:0]];
      end else if (a == `SLC_PDC_ADDR) begin
        readByte = lcdPinDutyControl_q;
      end else if (a == `SLC_DSC_ADDR) begin
        readByte = lcdDisplayControl_q;
      end else begin
        readByte = 8'h00;
      end
    end
  endfunction

  // Display bit for segment s in common phase p, RAM packed as s*n+p
  // RAM image is an argument so that combinational callers see RAM writes
  function ramPick;
    input [7:0] s;
    input [1:0] p;
    input [2:0] n;
    input [159:0] bits;
    reg [10:0] idx;
    begin
      idx = s * n + {9'h000, p};
      ramPick = (idx < 11'h0A0) ? bits[idx[7:0]] : 1'b0;
    end
  endfunction

  // Register writes; a word access writes the even byte from the high half
  task writeByte;
    input [15:0] a;
    input [7:0] d;
    reg [15:0] off;
    begin
      off = a - `SLC_RAM_BASE;
      if (a >= `SLC_RAM_BASE && off < {8'h00, `SLC_RAM_BYTES}) begin
        ramMem_q[off[4:0]] <= d;
      end else if (a == `SLC_PDC_ADDR) begin
        lcdPinDutyControl_q <= d;
      end else if (a == `SLC_DSC_ADDR) begin
        lcdDisplayControl_q <= d;
      end
    end
  endtask

  always @(posedge refClk) begin
    if (srst) begin
      lcdPinDutyControl_q <= `SLC_PDC_RESET;
      lcdDisplayControl_q <= `SLC_DSC_RESET;
      for (i = 0; i < 20; i = i + 1) begin
        ramMem_q[i] <= 8'h00;
      end
    end else if (busWrStb) begin
      if (busWordAcc) begin
        writeByte({busAddr[15:1], 1'b0}, busWrData[15:8]);
        writeByte({busAddr[15:1], 1'b1}, busWrData[7:0]);
      end else begin
        writeByte(busAddr, busWrData[7:0]);
      end
    end
  end

  always @(posedge refClk) begin
    if (srst) begin
      busRdData <= 16'h0000;
    end else if (busRdStb) begin
      if (busWordAcc) begin
        busRdData <= {readByte({busAddr[15:1], 1'b0}), readByte({busAddr[15:1], 1'b1})};
      end else begin
        busRdData <= {8'h00, readByte(busAddr)};
      end
    end else begin
      busRdData <= 16'h0000;
    end
  end

  // Common phase counter; polarity flips at the end of every frame
  always @(posedge refClk) begin
    if (srst) begin
      phase_q <= 2'h0;
      alt_q <= 1'b0;
    end else if (phase_q > lastPhase) begin
      // A shorter duty written mid-frame restarts the phase count at once
      phase_q <= 2'h0;
    end else if (phaseTick) begin
      if (phase_q >= lastPhase) begin
        phase_q <= 2'h0;
        alt_q <= ~alt_q;
      end else begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end

  // Number of segment groups driving, counted from the top group down
  always @* begin
    if (groupSel[3]) begin
      groupCount = groupSel[0] ? 4'hA : 4'h9;
    end else if (groupSel == 4'h0) begin
      groupCount = 4'h0;
    end else begin
      groupCount = {1'b0, groupSel[2:0]} + 4'h1;
    end
  end

  // External segment count per duty
  always @* begin
    case (dutySel)
      `SLC_DUTY_STATIC: extCount = `SLC_EXT_STATIC;
      `SLC_DUTY_HALF: extCount = `SLC_EXT_HALF;
      default: extCount = 8'h00;
    endcase
  end

  // Serial shift of external segments each phase, then a latch pulse
  always @(posedge refClk) begin
    if (srst || !displayRun || !expansionSel) begin
      shState_q <= SH_IDLE;
      shIdx_q <= 8'h00;
      shCount_q <= 8'h00;
      serialData_q <= 1'b0;
      shiftClock_q <= 1'b0;
      latchClock_q <= 1'b0;
    end else if (phaseTick && extCount != 8'h00) begin
      shState_q <= SH_SETUP;
      shIdx_q <= 8'h00;
      shCount_q <= extCount;
      shiftClock_q <= 1'b0;
      latchClock_q <= 1'b0;
    end else if (shiftTick) begin
      case (shState_q)
        SH_IDLE: begin
          latchClock_q <= 1'b0;
        end
        SH_SETUP: begin
          serialData_q <= ramPick(`SLC_INT_SEGS + shIdx_q, phase_q, comCount, ramBits) ^ alt_q;
          shiftClock_q <= 1'b0;
        end
        SH_HIGH: begin
          shiftClock_q <= 1'b1;
        end
        SH_LATCH: begin
          shiftClock_q <= 1'b0;
          latchClock_q <= 1'b1;
        end
        default: begin
          shiftClock_q <= 1'b0;
        end
      endcase
      case (shState_q)
        SH_SETUP: shState_q <= SH_HIGH;
        SH_HIGH: begin
          shIdx_q <= shIdx_q + 8'h01;
          shState_q <= (shIdx_q + 8'h01 >= shCount_q) ? SH_LATCH : SH_SETUP;
        end
        SH_LATCH: shState_q <= SH_IDLE;
        default: shState_q <= SH_IDLE;
      endcase
    end
  end

  // Pin drive, registered
  reg [39:0] segNext;
  reg [39:0] segPortNext;
  reg [3:0] comNext;
  reg [3:0] comPortNext;
  reg [3:0] comActive;
  reg [1:0] comSrc [0:3];
  reg comBlank;
  integer s;
  integer k;

  always @* begin
    // Which commons drive and which phase each follows
    comSrc[0] = 2'h0;
    comSrc[1] = 2'h1;
    comSrc[2] = 2'h2;
    comSrc[3] = 2'h3;
    comBlank = 1'b0;
    case (dutySel)
      `SLC_DUTY_STATIC: begin
        comActive = reuseCommons ? 4'hF : 4'h1;
        comSrc[1] = 2'h0;
        comSrc[2] = 2'h0;
        comSrc[3] = 2'h0;
      end
      `SLC_DUTY_HALF: begin
        comActive = reuseCommons ? 4'hF : 4'h3;
        if (reuseCommons) begin
          comSrc[1] = 2'h0;
          comSrc[2] = 2'h1;
          comSrc[3] = 2'h1;
        end
      end
      `SLC_DUTY_THIRD: begin
        comActive = reuseCommons ? 4'hF : 4'h7;
        comBlank = reuseCommons;
      end
      default: begin
        comActive = 4'hF;
      end
    endcase
    if (!expansionSel && groupSel == 4'h0) begin
      comActive = 4'h0;
    end
    for (k = 0; k < 4; k = k + 1) begin
      comPortNext[k] = ~comActive[k];
      if (!comActive[k] || !displayRun) begin
        comNext[k] = 1'b0;
      end else if (k == 3 && comBlank) begin
        comNext[k] = alt_q;
      end else begin
        comNext[k] = (phase_q == comSrc[k]) ^ alt_q;
      end
    end
    // Segments switch between driver and port a whole group at a time
    for (s = 0; s < 40; s = s + 1) begin
      segPortNext[s] = (s / 4) < (`SLC_SEG_GROUPS - groupCount);
      segNext[s] = (displayRun && !segPortNext[s]) ?
                   (ramPick(s[7:0], phase_q, comCount, ramBits) ^ alt_q) : 1'b0;
    end
    if (expansionSel) begin
      segPortNext[39:36] = 4'h0;
      segNext[39] = latchClock_q;
      segNext[38] = shiftClock_q;
      segNext[37] = serialData_q;
      segNext[36] = displayRun & alt_q;
    end
  end

  always @(posedge refClk) begin
    if (srst) begin
      frontPlaneOutputs <= 40'h00_0000_0000;
      frontPlanePortMode <= 40'hFF_FFFF_FFFF;
      backPlaneOutputs <= 4'h0;
      backPlanePortMode <= 4'hF;
    end else begin
      frontPlaneOutputs <= segNext;
      frontPlanePortMode <= segPortNext;
      backPlaneOutputs <= comNext;
      backPlanePortMode <= comPortNext;
    end
  end
endmodule
`default_nettype wire

// file: verification/slc_props.sv
// Checker of the segment LCD controller pins
`timescale 1ns/100ps
`default_nettype none
module slc_props (
  // Clock and reset
  input wire refClk,
  input wire srst,
  // Register port
  input wire [15:0] busAddr,
  input wire [15:0] busWrData,
  input wire busWordAcc,
  input wire busWrStb,
  input wire busRdStb,
  input wire [15:0] busRdData,
  // Mode and pins
  input wire standbyReq,
  input wire [39:0] frontPlaneOutputs,
  input wire [39:0] frontPlanePortMode,
  input wire [3:0] backPlaneOutputs,
  input wire [3:0] backPlanePortMode
);
  reg [7:0] pdcQ;
  reg dispOnQ;
  reg [3:0] calmQ;
  reg sbyQ;
  wire hit = busWrStb && busAddr[15:1] == 15'h7FE0;
  wire [1:0] duty = pdcQ[7:6];
  wire reuse = pdcQ[5];
  wire expo = pdcQ[4];
  wire [3:0] grp = pdcQ[3:0];
  wire act = expo || grp != 4'h0;
  // Settled: no control write or standby change for six cycles
  wire calm = calmQ > 4'h5;
  wire live = calm && dispOnQ && !standbyReq;
  wire [3:0] nGrp = grp == 4'h0 ? {3'h0, expo} : grp[3] ? 4'h9 + {3'h0, grp[0]} : grp + 4'h1;
  wire [40:0] fpmExp = (41'h1 << (40 - 4 * nGrp)) - 41'h1;
  wire [3:0] bpmExp = !act ? 4'hF : (reuse || duty == 2'h3) ? 4'h0 : 4'hF << (duty + 2'h1);
  always @(posedge refClk) begin
    sbyQ <= standbyReq;
    if (srst) begin
      pdcQ <= 8'h00;
      dispOnQ <= 1'b1;
      calmQ <= 4'h0;
    end else begin
      if (hit && busWordAcc) begin
        pdcQ <= busWrData[15:8];
        dispOnQ <= busWrData[7];
      end else if (hit && !busAddr[0]) begin
        pdcQ <= busWrData[7:0];
      end else if (hit) begin
        dispOnQ <= busWrData[7];
      end
      if (hit || sbyQ != standbyReq) begin
        calmQ <= 4'h0;
      end else if (calmQ != 4'hF) begin
        calmQ <= calmQ + 4'h1;
      end
    end
  end
  default clocking cb @(posedge refClk);
  endclocking
  default disable iff (srst);
  sequence latchHold;
    frontPlaneOutputs[39] [*4] ##1 !frontPlaneOutputs[39];
  endsequence
  sequence shiftHold;
    frontPlaneOutputs[38] [*4] ##1 !frontPlaneOutputs[38];
  endsequence
  rd_idle_a: assert property (!$past(busRdStb) |-> busRdData == 16'h0000)
    else $error("read data outside its cycle");
  port_quiet_a: assert property ((frontPlaneOutputs & frontPlanePortMode) == 40'h0 &&
    (backPlaneOutputs & backPlanePortMode) == 4'h0) else $error("port pin driven");
  seg_port_a: assert property (calm |-> frontPlanePortMode == fpmExp[39:0])
    else $error("segment port groups wrong");
  com_port_a: assert property (calm |-> backPlanePortMode == bpmExp)
    else $error("common port modes wrong");
  stat_copy_a: assert property (calm && act && duty == 2'h0 && reuse |->
    backPlaneOutputs == {4{backPlaneOutputs[0]}}) else $error("static commons differ");
  half_copy_a: assert property (calm && act && duty == 2'h1 && reuse |->
    backPlaneOutputs[3] == backPlaneOutputs[2] && backPlaneOutputs[1] == backPlaneOutputs[0])
    else $error("half duty copies differ");
  third_pol_a: assert property (live && expo && duty == 2'h2 && reuse |->
    backPlaneOutputs[3] == frontPlaneOutputs[36]) else $error("fourth common selects");
  pol_static_a: assert property (live && expo && duty == 2'h0 |->
    backPlaneOutputs[0] != frontPlaneOutputs[36]) else $error("alternating signal wrong");
  standby_off_a: assert property (calm && (standbyReq || !dispOnQ) |->
    frontPlaneOutputs == 40'h0 && backPlaneOutputs == 4'h0) else $error("pins driven in standby");
  latch_hold_a: assert property ($rose(frontPlaneOutputs[39]) && expo && calm |-> latchHold)
    else $error("latch clock length wrong");
  shift_hold_a: assert property ($rose(frontPlaneOutputs[38]) && expo && calm |-> shiftHold)
    else $error("shift clock length wrong");
  data_hold_a: assert property (expo && calm && frontPlaneOutputs[38] && $past(frontPlaneOutputs[38])
    |-> $stable(frontPlaneOutputs[37])) else $error("serial data moved");
endmodule
bind slc_top slc_props slc_props_i (.refClk(refClk), .srst(srst), .busAddr(busAddr),
  .busWrData(busWrData), .busWordAcc(busWordAcc), .busWrStb(busWrStb), .busRdStb(busRdStb),
  .busRdData(busRdData), .standbyReq(standbyReq), .frontPlaneOutputs(frontPlaneOutputs),
  .frontPlanePortMode(frontPlanePortMode), .backPlaneOutputs(backPlaneOutputs),
  .backPlanePortMode(backPlanePortMode));
`default_nettype wire

// file: verification/slc_exp_model.sv
// Model of the external segment expansion driver
`timescale 1ns/100ps
`default_nettype none
module slc_exp_model (
  // Link from the controller
  input wire latchClk,
  input wire shiftClk,
  input wire serialIn,
  input wire polarity,
  // Bits shifted between the last two latches, the last eight display bits and latch count
  output reg [7:0] lastBits,
  output reg [7:0] lastTail,
  output reg [7:0] latchCount
);
  reg [7:0] bitCnt = 8'h00;
  reg [7:0] baseCnt = 8'h00;
  reg [7:0] shReg = 8'h00;
  initial lastBits = 8'h00;
  initial lastTail = 8'h00;
  initial latchCount = 8'h00;
  // One bit taken per rising shift clock, polarity removed
  always @(posedge shiftClk) begin
    bitCnt <= bitCnt + 8'h01;
    shReg <= {shReg[6:0], serialIn ^ polarity};
  end
  always @(posedge latchClk) begin
    lastBits <= bitCnt - baseCnt;
    lastTail <= shReg;
    baseCnt <= bitCnt;
    latchCount <= latchCount + 8'h01;
  end
endmodule
`default_nettype wire

// file: verification/segment_lcd_controller_tb.sv
// Self-checking testbench of the segment LCD controller
`timescale 1ns/100ps
`default_nettype none
module segment_lcd_controller_tb;
  reg refClk = 1'b0;
  reg srst = 1'b1;
  reg [15:0] busAddr = 16'h0000;
  reg [15:0] busWrData = 16'h0000;
  reg busWordAcc = 1'b0;
  reg busWrStb = 1'b0;
  reg busRdStb = 1'b0;
  reg standbyReq = 1'b0;
  wire [15:0] busRdData;
  wire [39:0] fpo;
  wire [39:0] fpm;
  wire [3:0] bpo;
  wire [3:0] bpm;
  wire [7:0] extBits;
  wire [7:0] extTail;
  wire [7:0] latchCount;
  integer fails = 0;
  integer check_count = 0;
  reg [15:0] rdv;
  always #5 refClk = ~refClk;
  slc_top #(.PHASE_BASE(24'h00_0400)) slc_top_i (.refClk(refClk), .srst(srst),
    .busAddr(busAddr), .busWrData(busWrData), .busWordAcc(busWordAcc), .busWrStb(busWrStb),
    .busRdStb(busRdStb), .busRdData(busRdData), .standbyReq(standbyReq),
    .frontPlaneOutputs(fpo), .frontPlanePortMode(fpm), .backPlaneOutputs(bpo),
    .backPlanePortMode(bpm));
  slc_exp_model slc_exp_model_i (.latchClk(fpo[39]), .shiftClk(fpo[38]),
    .serialIn(fpo[37]), .polarity(fpo[36]), .lastBits(extBits), .lastTail(extTail),
    .latchCount(latchCount));
  task chk_bus(input string what, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task chk_pin(input string what, input [39:0] e, input [39:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task wr(input [15:0] a, input [15:0] d, input w);
    begin
      @(posedge refClk);
      busAddr <= a;
      busWrData <= d;
      busWordAcc <= w;
      busWrStb <= 1'b1;
      @(posedge refClk);
      busWrStb <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input w);
    begin
      @(posedge refClk);
      busAddr <= a;
      busWordAcc <= w;
      busRdStb <= 1'b1;
      @(posedge refClk);
      busRdStb <= 1'b0;
      #1 rdv = busRdData;
    end
  endtask
  task t_reset;
    begin
      rd(16'hFFC0, 1'b0);
      chk_bus("pin ctrl", 16'h0000, rdv);
      rd(16'hFFC0, 1'b1);
      chk_bus("ctrl word", 16'h0080, rdv);
      chk_pin("seg ports", 40'hFF_FFFF_FFFF, fpm);
      chk_pin("com ports", 40'hF, {36'h0, bpm});
    end
  endtask
  task t_ram;
    begin
      wr(16'hF740, 16'hA55A, 1'b1);
      wr(16'hF753, 16'h003C, 1'b0);
      wr(16'hF754, 16'h00FF, 1'b0);
      rd(16'hF741, 1'b0);
      chk_bus("ram byte", 16'h005A, rdv);
      rd(16'hF740, 1'b1);
      chk_bus("ram word", 16'hA55A, rdv);
      rd(16'hF752, 1'b1);
      chk_bus("ram top", 16'h003C, rdv);
      rd(16'hF754, 1'b0);
      chk_bus("unmapped", 16'h0000, rdv);
    end
  endtask
  task t_seg;
    begin
      wr(16'hFFC0, 16'h0009, 1'b0);
      repeat (4) @(posedge refClk);
      #1 chk_pin("seg drive", 40'h0, fpm);
      chk_pin("seg data", 40'hA5, {32'h0, fpo[7:0] ^ {8{~bpo[0]}}});
      chk_pin("com used", 40'hE, {36'h0, bpm});
    end
  endtask
  task t_modes;
    integer m;
    reg [3:0] e;
    begin
      for (m = 0; m < 8; m = m + 1) begin
        wr(16'hFFC0, {8'h00, m[2:1], m[0], 5'h01}, 1'b0);
        e = (m[0] || m[2:1] == 2'h3) ? 4'h0 : 4'hF << (m[2:1] + 2'h1);
        repeat (2100) @(posedge refClk);
        #1 chk_pin("com mode", {36'h0, e}, {36'h0, bpm});
      end
    end
  endtask
  task t_exp(input [7:0] pdc, input [7:0] n, input [7:0] tail);
    reg [7:0] c;
    integer k;
    begin
      wr(16'hFFC0, {8'h00, pdc}, 1'b0);
      c = latchCount;
      for (k = 0; k < 3000 && latchCount - c < 8'h02; k = k + 1) @(posedge refClk);
      #1 chk_pin("link pins", {4'h0, {36{1'b1}}}, fpm);
      if (n == 8'h00) begin
        chk_pin("no latch", 40'h0, {32'h0, latchCount - c});
      end else begin
        chk_pin("ext count", {32'h0, n}, {32'h0, extBits});
        chk_pin("ext tail", {32'h0, tail}, {32'h0, extTail});
      end
    end
  endtask
  task t_frame;
    integer n;
    reg b;
    begin
      wr(16'hFFC1, 16'h0081, 1'b0);
      rd(16'hFFC1, 1'b0);
      chk_bus("disp ctrl", 16'h0081, rdv);
      b = bpo[0];
      for (n = 0; n < 3000 && bpo[0] == b; n = n + 1) begin
        @(posedge refClk);
        #1;
      end
      b = bpo[0];
      for (n = 0; n < 3000 && bpo[0] == b; n = n + 1) begin
        @(posedge refClk);
        #1;
      end
      chk_bus("frame period", 16'h0800, n[15:0]);
    end
  endtask
  task t_std;
    begin
      wr(16'hFFC0, 16'h00C0, 1'b0);
      repeat (4) @(posedge refClk);
      #1 chk_pin("quarter off", 40'hF, {36'h0, bpm});
      wr(16'hFFC0, 16'h0009, 1'b0);
      standbyReq <= 1'b1;
      repeat (10) @(posedge refClk);
      #1 chk_pin("standby segs", 40'h0, fpo);
      chk_pin("standby coms", 40'h0, {36'h0, bpo});
      @(posedge refClk);
      standbyReq <= 1'b0;
      repeat (10) @(posedge refClk);
      #1 chk_pin("wake data", 40'hA5, {32'h0, fpo[7:0] ^ {8{~bpo[0]}}});
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge refClk);
    srst <= 1'b0;
    t_reset;
    t_ram;
    t_seg;
    t_modes;
    t_exp(8'h10, 8'h7C, 8'h3C);
    t_exp(8'h50, 8'h2C, 8'h06);
    t_exp(8'hB0, 8'h00, 8'h00);
    t_std;
    t_frame;
    print_verdict;
  end
  // Cuts a hang short well past the expected run length
  initial begin
    #600_000;
    fails = fails + 1;
    print_verdict;
  end
endmodule
`default_nettype wire
